// [eepc_ctrl.sv]
// two-wire bus master that drives a password-protected serial eeprom
// assumes external pull-ups on scl and sda; the eeprom never stretches scl
// Function
// RULE_01: select byte is 1010, three chip enables, rw bit; msb first.
// RULE_02: two address bytes, high first; stop after last ack starts write.
// RULE_03: byte write nacked when locked, else acked; master then stops.
// RULE_04: page write carries one to four bytes inside one four-byte row.
// RULE_05: master never sends more page bytes than remain in the row.
// RULE_06: page bytes acked when unlocked, else nacked and memory kept.
// RULE_07: eeprom steps its in-page byte address after each page byte.
// RULE_08: busy eeprom nacks select; master repeats start plus select until ack. The code gives up after POLL_TRIES selects.
// RULE_09: reads work whatever the lock state.
// RULE_10: eeprom steps its address counter after each byte read.
// RULE_11: random read: write select, address, restart, read select, nack, stop.
// RULE_12: both selects of a random read share their upper seven bits.
// RULE_13: current read: read select, one byte, nack, stop.
// RULE_14: master acks to keep bytes coming, nacks the last then stops.
// RULE_15: eeprom address counter wraps to zero after the last address.
// RULE_16: eeprom samples ack in ninth slot and ends on nack.
// RULE_17: key-present: select with chip enable two, 09 00, key, 09, key.
// RULE_18: each 32-bit key copy goes most significant byte first.
// RULE_19: differing key copies skip the comparison.
// RULE_20: only a stop after the ninth-slot ack starts the compare delay.
// RULE_21: matching key unlocks protected sectors after the delay.
// RULE_22: unlock lasts until power off or next key-present.
// RULE_23: eeprom ignores the bus during the compare delay.
// RULE_24: key-write uses the same frame with code 07; stop starts write.
// RULE_25: new key taken only after valid key-present and equal copies.
// RULE_26: delivered key is zero and active.
// RULE_27: an unfinished key frame changes neither lock nor key.
`timescale 1ns/1ps
`default_nettype none
module eepc_ctrl #(
  parameter int POLL_TRIES = 64,
  parameter int FIFO_DEPTH = eepc_pkg::FIFO_DEPTH
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // command
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire eepc_pkg::eepc_cmd_t cmd,
  // write data
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [7:0] wr_data,
  // read data
  output logic rd_valid,
  output logic [7:0] rd_data,
  // status
  output eepc_pkg::eepc_stat_t stat,
  // bus pins
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  import eepc_pkg::*;

  if (POLL_TRIES < 1 || POLL_TRIES > 256) begin : g_bad_tries
    $error("eepc_ctrl poll tries must lie in 1..256");
  end

  function automatic logic is_key(input eepc_op_t op);
    is_key = (op == EEPC_OP_KEY_PRESENT) || (op == EEPC_OP_KEY_WRITE);
  endfunction : is_key

  function automatic logic [7:0] tx_byte(input eepc_cmd_t c, input logic [3:0] i,
                                         input logic rd, input logic [7:0] fd);
    logic [1:0] kb;
    kb = (i <= 4'h6) ? 2'(4'h6 - i) : 2'(IDX_KEY_LAST - i);
    if (i == 4'h0) begin
      tx_byte = {DEV_TYPE, is_key(c.op) ? {1'b1, c.chip_en[1:0]} : c.chip_en, rd};
    end else if (is_key(c.op)) begin
      if (i == 4'h1) tx_byte = KEY_ADDR_HI;
      else if (i == IDX_ADDR_LO) tx_byte = KEY_ADDR_LO;
      else if (i == IDX_CODE) begin
        tx_byte = (c.op == EEPC_OP_KEY_PRESENT) ? KEY_CODE_PRESENT : KEY_CODE_WRITE;
      end else tx_byte = c.key[kb*8 +: 8];
    end else if (i == 4'h1) tx_byte = c.addr[15:8];
    else if (i == IDX_ADDR_LO) tx_byte = c.addr[7:0];
    else tx_byte = fd;
  endfunction : tx_byte

  eepc_state_t st_r, st_nxt;
  eepc_cmd_t cmd_r;
  logic [QC_W-1:0] qc_r;
  logic [1:0] q_r;
  logic [3:0] bit_r, bit_nxt;
  logic [3:0] idx_r, idx_nxt;
  logic rdph_r, rdph_nxt;
  logic err_r, err_nxt;
  logic [7:0] tries_r, tries_nxt;
  logic [7:0] rem_r, rem_nxt;
  logic [2:0] wn_r;
  logic [2:0] drain_r;
  logic ack_r;
  logic [7:0] rxsh_r;
  logic [2:0] sync_r;
  logic sda_f_r;
  logic done_r;
  logic nack_r;
  logic rd_valid_r;
  logic [7:0] rd_data_r;

  // write data buffer
  wire f_valid;
  wire [7:0] f_data;
  wire f_pop;
  eepc_fifo #(.W(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(clk),
    .nrst(nrst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(wr_data),
    .out_valid(f_valid),
    .out_ready(f_pop),
    .out_data(f_data)
  );

  // decode
  wire accept = cmd_valid & cmd_ready;
  wire rd_sel = rdph_r | (cmd_r.op == EEPC_OP_READ_CUR);
  wire data_ph = (cmd_r.op == EEPC_OP_WRITE) && (idx_r > IDX_ADDR_LO);
  wire stall = (st_r == EEPC_ST_TX) && data_ph && !f_valid;
  wire tick = (qc_r == QC_W'(QTR_CYC - 1)) && !stall;
  wire bit_end = tick && (q_r == 2'h3);
  wire samp = tick && (q_r == 2'h2);
  wire ack_slot = bit_r == ACK_SLOT;
  wire [7:0] cur_byte = tx_byte(cmd_r, idx_r, rd_sel, f_data);
  wire tx_bit = cur_byte[3'h7 - bit_r[2:0]];
  wire last_tx = (rd_sel || cmd_r.op == EEPC_OP_POLL) ? (idx_r == 4'h0) :
                 is_key(cmd_r.op) ? (idx_r == IDX_KEY_LAST) :
                 (cmd_r.op == EEPC_OP_READ_RAND) ? (idx_r == IDX_ADDR_LO) :
                 (idx_r == IDX_ADDR_LO + {1'b0, wn_r});
  wire poll_again = (cmd_r.op == EEPC_OP_POLL) && err_r && (tries_r != 8'h00);
  wire [2:0] room = 3'(PAGE_BYTES) - {1'b0, cmd.addr[1:0]};
  wire [2:0] len3 = (cmd.len == 8'h00) ? 3'h1 : (cmd.len > 8'(room)) ? room : cmd.len[2:0];
  wire tx_nack_end = bit_end && (st_r == EEPC_ST_TX) && ack_slot && !ack_r;
  wire [2:0] unsent = data_ph ? 3'(wn_r - 3'(idx_r - IDX_ADDR_LO)) : wn_r;

  // fifo pops the sent byte, or discards what an aborted write left behind
  assign f_pop = (bit_end && (st_r == EEPC_ST_TX) && ack_slot && data_ph) ||
                 ((drain_r != 3'h0) && f_valid);

  // pin drive
  wire start_sda = q_r[1];
  wire tx_sda = !ack_slot && !tx_bit;
  wire rx_sda = ack_slot && (rem_r != LEN_MIN);
  wire stop_sda = !q_r[1];
  wire mid_scl = (q_r == 2'h0) || (q_r == 2'h3);
  assign sda_oe = (st_r == EEPC_ST_START) ? start_sda :
                  (st_r == EEPC_ST_TX) ? tx_sda :
                  (st_r == EEPC_ST_RX) ? rx_sda :
                  (st_r == EEPC_ST_STOP) ? stop_sda : 1'b0;
  assign scl_oe = (st_r == EEPC_ST_STOP) ? (q_r == 2'h0) :
                  (st_r == EEPC_ST_IDLE) ? 1'b0 : mid_scl;
  assign sda_o = 1'b0;
  assign scl_o = 1'b0;

  assign cmd_ready = (st_r == EEPC_ST_IDLE) && (drain_r == 3'h0);
  assign rd_valid = rd_valid_r;
  assign rd_data = rd_data_r;
  assign stat = '{busy: st_r != EEPC_ST_IDLE, done: done_r, nack: nack_r};

  always_comb begin
    st_nxt = st_r;
    bit_nxt = bit_r;
    idx_nxt = idx_r;
    rdph_nxt = rdph_r;
    err_nxt = err_r;
    tries_nxt = tries_r;
    rem_nxt = rem_r;
    if (accept) begin
      st_nxt = EEPC_ST_START;
      bit_nxt = 4'h0;
      idx_nxt = 4'h0;
      rdph_nxt = 1'b0;
      err_nxt = 1'b0;
      tries_nxt = 8'(POLL_TRIES - 1);
      rem_nxt = (cmd.len == 8'h00) ? LEN_MIN : cmd.len;
    end else if (bit_end) begin
      case (st_r)
        EEPC_ST_START: begin
          st_nxt = EEPC_ST_TX;
          bit_nxt = 4'h0;
        end
        EEPC_ST_TX: begin
          bit_nxt = ack_slot ? 4'h0 : bit_r + 4'h1;
          if (ack_slot && !ack_r) begin
            err_nxt = 1'b1; // RULE_03
            st_nxt = EEPC_ST_STOP; // RULE_06
          end else if (ack_slot && !last_tx) begin
            idx_nxt = idx_r + 4'h1;
          end else if (ack_slot && cmd_r.op == EEPC_OP_READ_RAND && !rdph_r) begin
            rdph_nxt = 1'b1; // RULE_11
            idx_nxt = 4'h0;
            st_nxt = EEPC_ST_START;
          end else if (ack_slot && rd_sel) begin
            st_nxt = EEPC_ST_RX; // RULE_13
          end else if (ack_slot) begin
            st_nxt = EEPC_ST_STOP; // RULE_20
          end
        end
        EEPC_ST_RX: begin
          bit_nxt = ack_slot ? 4'h0 : bit_r + 4'h1;
          if (ack_slot && rem_r == LEN_MIN) st_nxt = EEPC_ST_STOP; // RULE_14
          else if (ack_slot) rem_nxt = rem_r - 8'h01;
        end
        EEPC_ST_STOP: begin
          if (poll_again) begin
            st_nxt = EEPC_ST_START; // RULE_08
            err_nxt = 1'b0;
            tries_nxt = tries_r - 8'h01;
          end else begin
            st_nxt = EEPC_ST_IDLE;
          end
        end
        default: st_nxt = EEPC_ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      st_r <= EEPC_ST_IDLE;
      bit_r <= 4'h0;
      idx_r <= 4'h0;
      rdph_r <= 1'b0;
      err_r <= 1'b0;
      tries_r <= 8'h00;
      rem_r <= LEN_MIN;
    end else begin
      st_r <= st_nxt;
      bit_r <= bit_nxt;
      idx_r <= idx_nxt;
      rdph_r <= rdph_nxt;
      err_r <= err_nxt;
      tries_r <= tries_nxt;
      rem_r <= rem_nxt;
    end
  end

  // quarter-bit timing
  always_ff @(posedge clk) begin
    if (!nrst || accept) begin
      qc_r <= '0;
      q_r <= 2'h0;
    end else if (st_r != EEPC_ST_IDLE && !stall) begin
      qc_r <= tick ? '0 : qc_r + QC_W'(1);
      q_r <= q_r + 2'(tick);
    end
  end

  // command capture, page clamp and leftover discard
  always_ff @(posedge clk) begin
    if (!nrst) begin
      cmd_r <= '0;
      wn_r <= 3'h1;
      drain_r <= 3'h0;
    end else begin
      if (accept) begin
        cmd_r <= cmd; // RULE_12
        wn_r <= len3; // RULE_05
      end
      // the nacked byte is popped with its ack slot; unsent counts only those after it
      if (tx_nack_end && cmd_r.op == EEPC_OP_WRITE) drain_r <= unsent;
      else if (drain_r != 3'h0 && f_valid) drain_r <= drain_r - 3'h1;
    end
  end

  // sda input: three stages, a level counts once the last two agree
  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_r <= SYNC_RST;
      sda_f_r <= 1'b1;
    end else begin
      sync_r <= {sync_r[1:0], sda_i};
      if (sync_r[1] == sync_r[2]) sda_f_r <= sync_r[2];
    end
  end

  // sampling and results
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ack_r <= 1'b0;
      rxsh_r <= 8'h00;
      done_r <= 1'b0;
      nack_r <= 1'b0;
      rd_valid_r <= 1'b0;
      rd_data_r <= 8'h00;
    end else begin
      if (samp && st_r == EEPC_ST_TX && ack_slot) ack_r <= !sda_f_r;
      if (samp && st_r == EEPC_ST_RX && !ack_slot) rxsh_r <= {rxsh_r[6:0], sda_f_r};
      done_r <= bit_end && st_r == EEPC_ST_STOP && !poll_again;
      if (bit_end && st_r == EEPC_ST_STOP && !poll_again) nack_r <= err_r;
      rd_valid_r <= bit_end && st_r == EEPC_ST_RX && ack_slot;
      if (bit_end && st_r == EEPC_ST_RX && ack_slot) rd_data_r <= rxsh_r;
    end
  end

  chk_sel_type: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
    (st_r == EEPC_ST_TX && idx_r == 4'h0 && bit_r < 4'h4 && q_r == 2'h1)
    |-> sda_oe == !DEV_TYPE[2'(3'h3 - bit_r[2:0])])
    else $error("select type bits wrong");
  chk_rw_bit: assert property (@(posedge clk) disable iff (!nrst) // RULE_01
    (st_r == EEPC_ST_TX && idx_r == 4'h0 && bit_r == 4'h7 && q_r == 2'h1)
    |-> sda_oe == !(rdph_r || cmd_r.op == EEPC_OP_READ_CUR))
    else $error("rw bit wrong");
  chk_addr_hi: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
    (st_r == EEPC_ST_TX && idx_r == 4'h1 && bit_r == 4'h0 && q_r == 2'h1 &&
     !is_key(cmd_r.op)) |-> sda_oe == !cmd_r.addr[15])
    else $error("address high byte not first");
  chk_page_row: assert property (@(posedge clk) disable iff (!nrst) // RULE_04
    (st_r != EEPC_ST_IDLE && cmd_r.op == EEPC_OP_WRITE)
    |-> (wn_r != 3'h0) && ({1'b0, wn_r} + {2'b00, cmd_r.addr[1:0]} <= 4'(PAGE_BYTES)))
    else $error("page write leaves its row");
  chk_key_frame: assert property (@(posedge clk) disable iff (!nrst) // RULE_17
    (st_r == EEPC_ST_TX && is_key(cmd_r.op) && idx_r == IDX_CODE)
    |-> cur_byte == ((cmd_r.op == EEPC_OP_KEY_PRESENT) ? 8'h09 : 8'h07)) // RULE_24
    else $error("validation code wrong");
  chk_key_msb: assert property (@(posedge clk) disable iff (!nrst) // RULE_18
    (st_r == EEPC_ST_TX && is_key(cmd_r.op) && (idx_r == IDX_KEY1 || idx_r == IDX_KEY2))
    |-> cur_byte == cmd_r.key[31:24])
    else $error("key not sent msb first");
  chk_last_nack: assert property (@(posedge clk) disable iff (!nrst) // RULE_16
    (st_r == EEPC_ST_RX && ack_slot && rem_r == LEN_MIN && bit_end)
    |-> !sda_oe ##1 st_r == EEPC_ST_STOP)
    else $error("last read byte not nacked then stopped");
  chk_more_ack: assert property (@(posedge clk) disable iff (!nrst) // RULE_14
    (st_r == EEPC_ST_RX && ack_slot && rem_r != LEN_MIN && q_r == 2'h1) |-> sda_oe)
    else $error("sequential read not acked");
  chk_write_stop: assert property (@(posedge clk) disable iff (!nrst) // RULE_03
    (bit_end && st_r == EEPC_ST_TX && ack_slot && last_tx && !rd_sel &&
     cmd_r.op != EEPC_OP_READ_RAND) |=> st_r == EEPC_ST_STOP && q_r == 2'h0)
    else $error("write frame not closed by stop");
  chk_poll_retry: assert property (@(posedge clk) disable iff (!nrst) // RULE_08
    (bit_end && st_r == EEPC_ST_STOP && poll_again)
    |=> st_r == EEPC_ST_START && !err_r && tries_r == $past(tries_r) - 8'h01)
    else $error("poll did not retry");
  chk_data_stable: assert property (@(posedge clk) disable iff (!nrst) // RULE_02
    (st_r == EEPC_ST_TX && $past(st_r) == EEPC_ST_TX && $changed(sda_oe)) |-> scl_oe)
    else $error("sda moved while scl high");
endmodule : eepc_ctrl
`default_nettype wire

// [eepc_eeprom_model.sv]
// behavioural two-wire eeprom with write lock and a 32-bit key
// assumes scl and sda are the resolved open-drain levels made by the bench
`timescale 1ns/1ps
`default_nettype none
module eepc_eeprom_model #(
  parameter int AW = 11,
  parameter int WC = 1500
) (
  // clock and bus
  input wire logic clk,
  input wire logic scl,
  input wire logic sda,
  output logic sda_oe,
  // write-lock bit
  input wire logic lock
);
  logic [7:0] mem [0:(1<<AW)-1];
  logic [7:0] pb [0:3];
  logic [AW-1:0] pa [0:3];
  logic [AW-1:0] ac = '0;
  logic [7:0] sh = '0, hi = '0, code = '0;
  logic [31:0] key = 32'h0, k1 = '0, k2 = '0;
  logic [3:0] cnt = '0;
  logic act = 1'b0, rdq = 1'b0, kf = 1'b0, ackq = 1'b0, grant = 1'b0;
  int idx = 0, n_pg = 0, busy = 0;

  initial begin
    sda_oe = 1'b0;
    foreach (mem[i]) mem[i] = 8'hff;
  end

  always @(posedge clk) if (busy > 0) busy = busy - 1;

  // decode one received byte and decide the acknowledge
  task automatic take_byte;
    ackq = 1'b1;
    if (idx == 0) begin
      ackq = (sh[7:4] == 4'ha);
      kf = sh[3];
      rdq = ackq && sh[0];
    end else if (kf) begin
      if (idx == 1) ackq = (sh == 8'h09);
      else if (idx == 2) ackq = (sh == 8'h00);
      else if (idx < 7) k1 = {k1[23:0], sh};
      else if (idx == 7) begin
        code = sh;
        ackq = (sh == 8'h09) || (sh == 8'h07);
      end else if (idx < 12) k2 = {k2[23:0], sh};
      else ackq = 1'b0;
    end else if (idx == 1) hi = sh;
    else if (idx == 2) ac = AW'({hi, sh});
    else begin
      ackq = !lock || grant;
      if (ackq) begin
        pa[n_pg[1:0]] = {ac[AW-1:2], 2'(ac[1:0] + n_pg)};
        pb[n_pg[1:0]] = sh;
        n_pg++;
      end
    end
    idx++;
  endtask : take_byte

  always @(negedge sda) if (scl) begin
    act = (busy == 0);
    cnt = '0;
    idx = 0;
    n_pg = 0;
    rdq = 1'b0;
    ackq = 1'b0;
    sda_oe = 1'b0;
  end

  // stop: only right after an ack slot does anything start
  always @(posedge sda) if (scl && act) begin
    act = 1'b0;
    if (cnt == 1 && kf && idx == 12) begin
      busy = WC;
      if (k1 == k2 && code == 8'h09) grant = (k1 == key);
      if (k1 == k2 && code == 8'h07 && grant) key = k1;
    end else if (cnt == 1 && !kf && n_pg > 0) begin
      busy = WC;
      for (int i = 0; i < n_pg && i < 4; i++) mem[pa[i]] = pb[i];
    end
  end

  always @(posedge scl) if (act) begin
    if (cnt == 8) begin
      if (rdq && sda) act = 1'b0;
      cnt = 4'h9;
    end else begin
      if (!rdq) sh = {sh[6:0], sda};
      cnt = cnt + 1'b1;
      if (cnt == 8 && !rdq) take_byte();
    end
  end

  always @(negedge scl) if (act) begin
    if (cnt == 8) sda_oe = ackq;
    else if (cnt == 9) begin
      cnt = '0;
      ackq = 1'b0;
      if (rdq) begin
        sh = mem[ac];
        ac = ac + 1'b1;
      end
      sda_oe = rdq && !sh[7];
    end else if (rdq && cnt != 0) sda_oe = !sh[4'h7 - cnt];
  end
endmodule : eepc_eeprom_model
`default_nettype wire

// [eepc_fifo.sv]
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none
module eepc_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [W-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [W-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);

  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("eepc_fifo depth must be a power of two of at least 2");
  end

  logic [W-1:0] mem_r [DEPTH];
  logic [AW-1:0] wp_r;
  logic [AW-1:0] rp_r;
  logic [AW:0] cnt_r;
  wire push = in_valid & in_ready;
  wire pop = out_valid & out_ready;

  assign in_ready = cnt_r != (AW+1)'(DEPTH);
  assign out_valid = cnt_r != '0;
  assign out_data = mem_r[rp_r];

  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wp_r] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_r + AW'(push);
      rp_r <= rp_r + AW'(pop);
      cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : eepc_fifo
`default_nettype wire

// [eepc_pkg.sv]
// constants and types for the two-wire eeprom access controller
// assumes a 20 MHz system clock and one eeprom on an open-drain bus
`default_nettype none
package eepc_pkg;

  // bus timing
  localparam int CLK_HZ = 20_000_000;
  localparam int SCL_HZ = 400_000;
  localparam int QTR_CYC = (CLK_HZ + 4 * SCL_HZ - 1) / (4 * SCL_HZ);
  localparam int QC_W = $clog2(QTR_CYC);

  // framing bytes and fields
  localparam logic [3:0] DEV_TYPE = 4'ha;
  localparam logic [7:0] KEY_ADDR_HI = 8'h09;
  localparam logic [7:0] KEY_ADDR_LO = 8'h00;
  localparam logic [7:0] KEY_CODE_PRESENT = 8'h09;
  localparam logic [7:0] KEY_CODE_WRITE = 8'h07;
  localparam int PAGE_BYTES = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;

  // byte indices within a frame, and the bit slot of the ack within a byte
  localparam logic [3:0] IDX_ADDR_LO = 4'h2;
  localparam logic [3:0] IDX_KEY1 = 4'h3;
  localparam logic [3:0] IDX_CODE = 4'h7;
  localparam logic [3:0] IDX_KEY2 = 4'h8;
  localparam logic [3:0] IDX_KEY_LAST = 4'hb;
  localparam logic [3:0] ACK_SLOT = 4'h8;

  // reset values
  localparam logic [7:0] LEN_MIN = 8'h01;
  localparam logic [2:0] SYNC_RST = 3'h7;

  typedef enum logic [2:0] {
    EEPC_OP_WRITE = 3'h0,
    EEPC_OP_READ_RAND = 3'h1,
    EEPC_OP_READ_CUR = 3'h2,
    EEPC_OP_KEY_PRESENT = 3'h3,
    EEPC_OP_KEY_WRITE = 3'h4,
    EEPC_OP_POLL = 3'h5
  } eepc_op_t;

  typedef enum logic [2:0] {
    EEPC_ST_IDLE = 3'b000,
    EEPC_ST_START = 3'b001,
    EEPC_ST_TX = 3'b011,
    EEPC_ST_RX = 3'b010,
    EEPC_ST_STOP = 3'b110
  } eepc_state_t;

  typedef struct packed {
    eepc_op_t op;
    logic [2:0] chip_en;
    logic [15:0] addr;
    logic [7:0] len;
    logic [31:0] key;
  } eepc_cmd_t;

  typedef struct packed {
    logic busy;
    logic done;
    logic nack;
  } eepc_stat_t;

endpackage : eepc_pkg
`default_nettype wire

// [tb_top.sv]
// self-checking bench for the eeprom access controller
// assumes the eeprom model and pull-ups on both bus lines
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import eepc_pkg::*;
  logic clk = 1'b0, nrst = 1'b0, cmd_valid = 1'b0, wr_valid = 1'b0, lock = 1'b0;
  logic cmd_ready, wr_ready, rd_valid, scl_oe, sda_oe, m_oe, scl_o, sda_o;
  logic [7:0] wr_data = 8'h00, rd_data;
  logic [7:0] exp_m [0:2047];
  logic [7:0] got [$], pend [$];
  logic [10:0] ra;
  eepc_cmd_t cmd = '0;
  eepc_stat_t stat;
  int n_errors = 0, tests_run = 0;
  wire logic scl = !scl_oe;
  wire logic sda = !(sda_oe || m_oe);

  eepc_ctrl #(.POLL_TRIES(2)) eepc_ctrl_i (.clk(clk), .nrst(nrst), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd(cmd), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .rd_valid(rd_valid), .rd_data(rd_data), .stat(stat), .scl_o(scl_o),
    .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe));
  eepc_eeprom_model #(.WC(1500)) eepc_eeprom_model_i (.clk(clk), .scl(scl), .sda(sda),
    .sda_oe(m_oe), .lock(lock));

  initial forever #25 clk = ~clk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] want);
    tests_run++;
    if (seen !== want) begin
      n_errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, want);
    end
  endtask : chk

  task automatic give_verdict;
    $display("counts: %0d checks, %0d mismatches", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : give_verdict

  task automatic fin(input string s);
    $display("test %s finished", s);
  endtask : fin

  task automatic push(input logic [7:0] d);
    int t;
    @(posedge clk);
    wr_valid <= 1'b1;
    wr_data <= d;
    pend.push_back(d);
    t = 0;
    do @(negedge clk); while (wr_ready !== 1'b1 && ++t < 100);
    @(posedge clk);
    wr_valid <= 1'b0;
  endtask : push

  task automatic run(input eepc_op_t op, input logic [2:0] ce, input logic [15:0] a,
      input logic [7:0] n, input logic [31:0] k);
    int t;
    got.delete();
    @(posedge clk);
    cmd_valid <= 1'b1;
    cmd <= '{op, ce, a, n, k};
    t = 0;
    do @(negedge clk); while (cmd_ready !== 1'b1 && ++t < 100);
    @(posedge clk);
    cmd_valid <= 1'b0;
    @(negedge clk);
    chk({stat.busy, scl_o, sda_o}, 32'h4);
    t = 0;
    do begin
      @(negedge clk);
      if (rd_valid === 1'b1) got.push_back(rd_data);
    end while (stat.done !== 1'b1 && ++t < 30000);
    if (t >= 30000) chk(32'h0, 32'h1);
    chk(stat.busy, 1'b0);
  endtask : run

  task automatic settle;
    run(EEPC_OP_POLL, 3'h0, 16'h0, 8'h0, 32'h0);
    chk(stat.nack, 1'b1);
    for (int i = 0; i < 20 && stat.nack === 1'b1; i++) run(EEPC_OP_POLL, 3'h0, 16'h0, 8'h0, 32'h0);
    chk(stat.nack, 1'b0);
  endtask : settle

  task automatic wr(input logic [15:0] a, input int n, input logic [7:0] len, input logic lk);
    logic [7:0] d;
    while (pend.size() < n) push(8'($urandom));
    for (int i = 0; i < n; i++) begin
      d = pend.pop_front();
      if (!lk) exp_m[{a[10:2], 2'(a[1:0] + i)}] = d;
    end
    run(EEPC_OP_WRITE, 3'h0, a, len, 32'h0);
    chk(stat.nack, lk);
    if (!lk) settle();
  endtask : wr

  task automatic rd(input eepc_op_t op, input logic [10:0] a, input int n);
    run(op, 3'h0, {5'h0, a}, n[7:0], 32'h0);
    chk(got.size(), n);
    foreach (got[i]) chk(got[i], exp_m[11'(a + i)]);
  endtask : rd

  task automatic key(input eepc_op_t op, input logic [31:0] k);
    run(op, 3'h0, 16'h0, 8'h0, k);
    chk(stat.nack, 1'b0);
    settle();
  endtask : key

  initial begin
    void'($urandom(73320));
    foreach (exp_m[i]) exp_m[i] = 8'hff;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    // fill the fifo until it refuses, then drain it through page writes
    repeat (16) push(8'($urandom));
    @(negedge clk);
    chk(wr_ready, 1'b0);
    for (int i = 0; i < 4; i++) wr(16'h0040 + 16'(4 * i), 4, 8'h04, 1'b0);
    rd(EEPC_OP_READ_RAND, 11'h040, 16);
    fin("page");
    wr(16'h0102, 2, 8'h04, 1'b0);
    rd(EEPC_OP_READ_RAND, 11'h100, 8);
    fin("row clamp");
    repeat (2) begin
      ra = 11'($urandom);
      wr({5'h0, ra}, 1, 8'h01, 1'b0);
      rd(EEPC_OP_READ_RAND, ra, 1);
      rd(EEPC_OP_READ_CUR, 11'(ra + 1), 1);
    end
    rd(EEPC_OP_READ_RAND, 11'h7ff, 2);
    rd(EEPC_OP_READ_CUR, 11'h001, 1);
    fin("random and wrap");
    lock = 1'b1;
    wr(16'h0200, 1, 8'h01, 1'b1);
    wr(16'h0204, 3, 8'h03, 1'b1);
    rd(EEPC_OP_READ_RAND, 11'h200, 8);
    key(EEPC_OP_KEY_PRESENT, 32'h0);
    wr(16'h0200, 1, 8'h01, 1'b0);
    key(EEPC_OP_KEY_WRITE, 32'h5a3c_9617);
    key(EEPC_OP_KEY_PRESENT, 32'h0);
    wr(16'h0201, 1, 8'h01, 1'b1);
    key(EEPC_OP_KEY_PRESENT, 32'h5a3c_9617);
    wr(16'h0201, 1, 8'h01, 1'b0);
    rd(EEPC_OP_READ_RAND, 11'h200, 4);
    fin("lock and key");
    give_verdict();
  end

  initial begin
    repeat (200000) @(posedge clk);
    n_errors++;
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
